// ===== verilog/wdt_core.sv
// Watchdog timer, power-up delay timer and brown-out flag
// Function
// RQ1 - While enabled the counter runs on low-power oscillator ticks and resets the device on expiry.
// RQ2 - A postscaler value picks one of several expiry intervals.
// RQ3 - Expiry while in Sleep or Idle wakes the device instead of resetting it.
// RQ4 - Control bit 15 written 1 enables, written 0 disables only a software enable.
// RQ5 - Control bit 15 reads 1 whenever the watchdog runs, by either enable.
// RQ6 - Bits 6 to 2 read the postscaler shadow, loaded from configuration at every reset.
// RQ7 - Bit 1 selects window mode, resets to 0 and is read-write.
// RQ8 - Writing 1 to bit 0 clears the count, writing 0 does nothing.
// RQ9 - Software avoids register access in the cycle right after clearing the enable bit.
// RQ10 - After any power-down, including Sleep, execution is held for a fixed power-up delay.
// RQ11 - A low regulator supply raises a brown-out reset and sets bit 1 of the reset control reg.
// RQ12 - Control bits 31 to 16 and 14 to 7 read zero and ignore writes.
// RQ13 - The counter restarts from zero on clear, enable and reset.
`timescale 1ns/100ps
module wdt_core (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Configuration and power state
  input  wire logic        cfgWdtEnable,
  input  wire logic [4:0]  cfgPostscaleSel,
  input  wire logic        lowPowerOsc,
  input  wire logic        sleepMode,
  input  wire logic        idleMode,
  input  wire logic        supplyLow,
  // Device control outputs
  output logic             wdtResetReq,
  output logic             wakeReq,
  output logic             execHold,
  output logic             brownoutReset
);
  wdt_tick_if tk ();

  wdt_tick_gen u_tick (
    .mclk   (mclk),
    .resetn (resetn),
    .tk     (tk.gen)
  );
  assign tk.oscLevel = lowPowerOsc;

  // Registers
  logic                  cfgEn_ff;
  logic                  swOn_ff;
  logic [4:0]            shadowPs_ff;
  logic                  winEn_ff;
  logic                  loadPend_ff;
  logic [wdt_pkg::CNT_W-1:0] count_ff;
  logic                  resetReq_ff;
  logic                  wakeReq_ff;
  logic                  brownFlag_ff;
  logic                  brownReset_ff;
  logic                  hold_ff;
  logic                  sleepPrev_ff;
  logic [wdt_pkg::PU_W-1:0]  puCnt_ff;
  wdt_pkg::wdt_pu_state_t    puState_ff;
  logic [31:0]           rdata_ff;

  // Decode
  wire ctrlSel   = regAddr == wdt_pkg::CTRL_OFS;
  wire rstCtlSel = regAddr == wdt_pkg::RSTCTL_OFS;
  wire ctrlWr    = regWr & ctrlSel;
  wire rstCtlWr  = regWr & rstCtlSel;
  wire running   = cfgEn_ff | swOn_ff;
  wire lowPower  = sleepMode | idleMode;
  // RQ8 clear on write one
  wire clrHit    = ctrlWr & regWdata[wdt_pkg::CLR_BIT];
  wire devReset  = resetReq_ff | brownReset_ff;

  // Postscaler limit
  // RQ2 selectable expiry period
  wire [4:0] psEff = (shadowPs_ff > wdt_pkg::PS_MAX) ? wdt_pkg::PS_MAX : shadowPs_ff;
  wire [wdt_pkg::CNT_W-1:0] limit    = wdt_pkg::BASE_TICKS << psEff;
  wire [wdt_pkg::CNT_W-1:0] lastCnt  = limit - wdt_pkg::CNT_ONE;
  wire [wdt_pkg::CNT_W-1:0] winStart = limit - (limit >> wdt_pkg::WIN_SHIFT);
  wire earlyClr = clrHit & running & winEn_ff & (count_ff < winStart);
  wire expire   = running & tk.tick & ~clrHit & (count_ff == lastCnt);

  // Read mux
  // RQ5 RQ12 enable read-back, zero gaps
  wire [31:0] ctrlRead   = {16'h0000, running, 8'h00, shadowPs_ff, winEn_ff, 1'b0};
  wire [31:0] rstCtlRead = {30'h0000_0000, brownFlag_ff, 1'b0};
  wire [31:0] nxt_rdata  = !regRd    ? wdt_pkg::ZERO_WORD :
                           ctrlSel   ? ctrlRead :
                           rstCtlSel ? rstCtlRead : wdt_pkg::ZERO_WORD;

  // Counter next value
  logic [wdt_pkg::CNT_W-1:0] nxt_count;
  always_comb
  begin
    nxt_count = count_ff;
    // RQ13 restart on disable or clear
    if (!running || clrHit || devReset)
      nxt_count = wdt_pkg::CNT_ZERO;
    // RQ1 count oscillator ticks
    else if (tk.tick)
      nxt_count = expire ? wdt_pkg::CNT_ZERO : count_ff + wdt_pkg::CNT_ONE;
  end

  // Enable, shadow and window controls
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfgEn_ff    <= 1'b0;
      swOn_ff     <= 1'b0;
      shadowPs_ff <= wdt_pkg::PS_RESET;
      winEn_ff    <= 1'b0;
      loadPend_ff <= 1'b1;
    end
    else
    begin
      loadPend_ff <= devReset;
      // RQ6 reload shadow after reset
      if (loadPend_ff)
      begin
        cfgEn_ff    <= cfgWdtEnable;
        shadowPs_ff <= cfgPostscaleSel;
        swOn_ff     <= 1'b0;
        winEn_ff    <= 1'b0;
      end
      else if (ctrlWr)
      begin
        // RQ4 software enable bit
        swOn_ff  <= regWdata[wdt_pkg::ON_BIT];
        // RQ7 window mode select
        winEn_ff <= regWdata[wdt_pkg::WIN_BIT];
      end
    end
  end

  // Counter and watchdog outputs
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_ff    <= wdt_pkg::CNT_ZERO;
      resetReq_ff <= 1'b0;
      wakeReq_ff  <= 1'b0;
    end
    else
    begin
      count_ff    <= nxt_count;
      // RQ1 expiry or early window clear resets
      resetReq_ff <= (expire & ~lowPower) | earlyClr;
      // RQ3 expiry wakes from Sleep or Idle
      wakeReq_ff  <= expire & lowPower;
    end
  end

  // Brown-out flag and reset
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      brownFlag_ff  <= 1'b0;
      brownReset_ff <= 1'b0;
    end
    else
    begin
      // RQ11 supply low sets flag, set wins over clear
      brownReset_ff <= supplyLow;
      if (supplyLow)
        brownFlag_ff <= 1'b1;
      else if (rstCtlWr && !regWdata[wdt_pkg::BROWN_BIT])
        brownFlag_ff <= 1'b0;
    end
  end

  // Power-up delay sequencer
  wire wakeEdge = sleepPrev_ff & ~sleepMode;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sleepPrev_ff <= 1'b0;
      puCnt_ff     <= wdt_pkg::PU_ZERO;
      puState_ff   <= wdt_pkg::PU_HOLD;
      hold_ff      <= 1'b1;
    end
    else
    begin
      sleepPrev_ff <= sleepMode;
      // RQ10 hold execution after power-down
      if (wakeEdge || devReset)
      begin
        puCnt_ff   <= wdt_pkg::PU_ZERO;
        puState_ff <= wdt_pkg::PU_HOLD;
        hold_ff    <= 1'b1;
      end
      else
      begin
        unique case (puState_ff)
          wdt_pkg::PU_HOLD:
          begin
            puCnt_ff <= puCnt_ff + 12'h001;
            if (puCnt_ff == wdt_pkg::PU_LAST)
            begin
              puState_ff <= wdt_pkg::PU_RUN;
              hold_ff    <= 1'b0;
            end
          end
          wdt_pkg::PU_RUN:
            puCnt_ff <= wdt_pkg::PU_ZERO;
          default:
          begin
            puState_ff <= wdt_pkg::PU_HOLD;
            hold_ff    <= 1'b1;
          end
        endcase
      end
    end
  end

  // Read data
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdata_ff <= wdt_pkg::ZERO_WORD;
    else
      rdata_ff <= nxt_rdata;
  end

  assign regRdata      = rdata_ff;
  assign wdtResetReq   = resetReq_ff;
  assign wakeReq       = wakeReq_ff;
  assign execHold      = hold_ff;
  assign brownoutReset = brownReset_ff;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_ctrl_read;
    regRd && ctrlSel;
  endsequence
  sequence s_wake_from_sleep;
    $fell(sleepMode) && !devReset;
  endsequence

  AST_EXPIRE_RESET: assert property (expire && !lowPower |=> wdtResetReq) // RQ1
    else $error("Expiry did not reset");
  AST_POSTSCALE: assert property (count_ff <= (wdt_pkg::BASE_TICKS << psEff) - 1) // RQ2
    else $error("Count beyond selected period");
  AST_WAKE: assert property (expire && lowPower |=> wakeReq && !wdtResetReq) // RQ3
    else $error("Expiry in low power did not wake");
  AST_CFG_STAYS: assert property (cfgEn_ff && ctrlWr && !loadPend_ff |=> running) // RQ4
    else $error("Configured watchdog was disabled");
  AST_ON_READ: assert property (s_ctrl_read |=> regRdata[wdt_pkg::ON_BIT] == $past(running)) // RQ5
    else $error("Enable read-back wrong");
  AST_SHADOW: assert property ($fell(loadPend_ff) |-> shadowPs_ff == $past(cfgPostscaleSel)) // RQ6
    else $error("Shadow not loaded");
  AST_WINDOW: assert property (ctrlWr && !loadPend_ff |=> winEn_ff == $past(regWdata[wdt_pkg::WIN_BIT])) // RQ7
    else $error("Window bit not written");
  AST_CLEAR: assert property (clrHit |=> count_ff == 0) // RQ8
    else $error("Clear did not zero count");
  AST_POWER_UP: assert property (s_wake_from_sleep |=> execHold [*8]) // RQ10
    else $error("Power-up hold too short");
  AST_BROWNOUT: assert property (supplyLow |=> brownoutReset && brownFlag_ff) // RQ11
    else $error("Brown-out not raised");
  AST_UNIMPL: assert property (s_ctrl_read |=> regRdata[31:16] == 0 && regRdata[14:7] == 0) // RQ12
    else $error("Unimplemented bits not zero");
  AST_RESTART: assert property ($rose(running) |-> count_ff == 0) // RQ13
    else $error("Counter not restarted on enable");
endmodule // wdt_core

// ===== common/wdt_pkg.sv
// Constants for the watchdog and power-up timer block
package wdt_pkg;
  // Register map (byte offsets)
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] RSTCTL_OFS = 8'h04;
  // Watchdog control fields
  localparam int ON_BIT  = 15;
  localparam int PS_LSB  = 2;
  localparam int PS_MSB  = 6;
  localparam int WIN_BIT = 1;
  localparam int CLR_BIT = 0;
  // Reset control fields
  localparam int BROWN_BIT = 1;
  // Reset values
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [4:0]  PS_RESET  = 5'h00;
  // Postscaler: time-out = base ticks shifted left by postscale value, limited to PS_MAX
  localparam int          CNT_W      = 26;
  localparam logic [25:0] BASE_TICKS = 26'h000_0020;
  localparam logic [4:0]  PS_MAX     = 5'h14;
  localparam int          WIN_SHIFT  = 2;
  // Power-up delay
  localparam int          CLK_PERIOD_PS     = 4000;
  localparam int          POWER_UP_DELAY_NS = 10000;
  localparam int          PU_CYCLES =
    (POWER_UP_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          PU_W      = 12;
  localparam logic [11:0] PU_LAST   = 12'(PU_CYCLES - 1);
  localparam logic [11:0] PU_ZERO   = 12'h000;
  localparam logic [25:0] CNT_ZERO  = 26'h000_0000;
  localparam logic [25:0] CNT_ONE   = 26'h000_0001;
  // Power-up sequencer states
  typedef enum logic [1:0] {
    PU_HOLD = 2'b01,
    PU_RUN  = 2'b10
  } wdt_pu_state_t;
endpackage

// ===== common/wdt_tick_if.sv
// Low-power oscillator sample and tick carrier
`timescale 1ns/100ps
interface wdt_tick_if;
  logic oscLevel;
  logic tick;
  modport gen  (input oscLevel, output tick);
  modport core (output oscLevel, input tick);
endinterface

// ===== verilog/wdt_tick_gen.sv
// Rising-edge tick generator for the low-power oscillator
`timescale 1ns/100ps
module wdt_tick_gen (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Oscillator sample and tick
  wdt_tick_if.gen  tk
);
  logic oscPrev_ff;
  logic tick_ff;
  wire  oscRise = tk.oscLevel & ~oscPrev_ff;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      oscPrev_ff <= 1'b0;
      tick_ff    <= 1'b0;
    end
    else
    begin
      oscPrev_ff <= tk.oscLevel;
      tick_ff    <= oscRise;
    end
  end

  assign tk.tick = tick_ff;
endmodule // wdt_tick_gen

// ===== bench/tb.sv
// Self-checking bench for the watchdog and power-up timer
`timescale 1ns/100ps
module tb;
  logic        mclk;
  logic        resetn;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        cfgWdtEnable;
  logic [4:0]  cfgPostscaleSel;
  logic        lowPowerOsc;
  logic        sleepMode;
  logic        idleMode;
  logic        supplyLow;
  logic        wdtResetReq;
  logic        wakeReq;
  logic        execHold;
  logic        brownoutReset;
  int          num_errors;
  int          total_checks;
  int          rstCnt;
  int          wakeCnt;
  int          n;

  wdt_core dut (
    .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cfgWdtEnable(cfgWdtEnable),
    .cfgPostscaleSel(cfgPostscaleSel), .lowPowerOsc(lowPowerOsc), .sleepMode(sleepMode),
    .idleMode(idleMode), .supplyLow(supplyLow), .wdtResetReq(wdtResetReq),
    .wakeReq(wakeReq), .execHold(execHold), .brownoutReset(brownoutReset)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Pulse counters, cleared by reset
  always @(posedge mclk)
  begin
    rstCnt <= resetn ? rstCnt + (wdtResetReq === 1'b1) : 0;
    wakeCnt <= resetn ? wakeCnt + (wakeReq === 1'b1) : 0;
  end

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_sim;
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task doReset(input logic en, input logic [4:0] ps);
    @(posedge mclk);
    resetn <= 1'b0;
    cfgWdtEnable <= en;
    cfgPostscaleSel <= ps;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 cmp(regRdata, exp);
  endtask

  task ticks(input int k);
    repeat (k)
    begin
      @(posedge mclk);
      lowPowerOsc <= 1'b1;
      @(posedge mclk);
      lowPowerOsc <= 1'b0;
    end
    repeat (6) @(posedge mclk);
  endtask

  // Cycles until execution hold drops
  task waitHold;
    n = 0;
    while (execHold !== 1'b0)
    begin
      @(posedge mclk);
      #1 n++;
      if (n > 3000)
      begin
        num_errors++;
        end_sim;
      end
    end
  endtask

  task t_regs;
    doReset(1'b0, 5'h03);
    rd(8'h00, 32'h0000_000C);
    wr(8'h00, 32'hFFFF_7FFE);
    rd(8'h00, 32'h0000_000E);
    wr(8'h00, 32'h0000_0000);
    rd(8'h00, 32'h0000_000C);
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, 32'h0000_0000);
    rd(8'h00, 32'h0000_000C);
  endtask

  task t_enable;
    doReset(1'b0, 5'h00);
    wr(8'h00, 32'h0000_8000);
    rd(8'h00, 32'h0000_8000);
    wr(8'h00, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    ticks(40);
    cmp(rstCnt, 0);
    doReset(1'b1, 5'h03);
    rd(8'h00, 32'h0000_800C);
    wr(8'h00, 32'h0000_0000);
    rd(8'h00, 32'h0000_800C);
    wr(8'h00, 32'h0000_8002);
    wr(8'h00, 32'h0000_8003);
    repeat (4) @(posedge mclk);
    cmp(rstCnt, 1);
  endtask

  task t_expire(input logic [4:0] ps);
    doReset(1'b0, ps);
    wr(8'h00, 32'h0000_8000);
    ticks((32 << ps) - 1);
    cmp(rstCnt, 0);
    ticks(1);
    cmp(rstCnt, 1);
    cmp(wakeCnt, 0);
  endtask

  task t_clear;
    doReset(1'b0, 5'h00);
    wr(8'h00, 32'h0000_8000);
    ticks(20);
    wr(8'h00, 32'h0000_8001);
    ticks(20);
    cmp(rstCnt, 0);
    ticks(12);
    cmp(rstCnt, 1);
  endtask

  task t_sleep;
    doReset(1'b0, 5'h00);
    waitHold;
    cmp(n, wdt_pkg::PU_CYCLES - 2);
    wr(8'h00, 32'h0000_8000);
    idleMode <= 1'b1;
    ticks(32);
    cmp(wakeCnt, 1);
    idleMode <= 1'b0;
    wr(8'h00, 32'h0000_8001);
    sleepMode <= 1'b1;
    ticks(32);
    cmp(wakeCnt, 2);
    cmp(rstCnt, 0);
    sleepMode <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 cmp(execHold, 1);
    waitHold;
    cmp(n, wdt_pkg::PU_CYCLES - 1);
  endtask

  task t_brown;
    doReset(1'b0, 5'h00);
    supplyLow <= 1'b1;
    @(posedge mclk);
    #1 cmp(brownoutReset, 1);
    @(posedge mclk);
    supplyLow <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 cmp(brownoutReset, 0);
    rd(8'h04, 32'h0000_0002);
    wr(8'h04, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
  endtask

  initial
  begin
    resetn = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWr = 1'b0;
    regRd = 1'b0;
    cfgWdtEnable = 1'b0;
    cfgPostscaleSel = 5'h00;
    lowPowerOsc = 1'b0;
    sleepMode = 1'b0;
    idleMode = 1'b0;
    supplyLow = 1'b0;
    num_errors = 0;
    total_checks = 0;
    t_regs;
    t_enable;
    for (int p = 0; p < 3; p++)
      t_expire(5'(p));
    t_clear;
    t_sleep;
    t_brown;
    end_sim;
  end
endmodule // tb
